/* rtl/rcd_regs.svh */
`ifndef RCD_REGS_SVH
`define RCD_REGS_SVH
// ----------------------------------------
// Register indices and byte addresses
// ----------------------------------------
`define RCD_IDX_DEC      12'h090
`define RCD_IDX_ITP      12'h091
`define RCD_IDX_RSC      12'h092
`define RCD_IDX_C5       12'h093
`define RCD_IDX_STAT     12'h094
`define RCD_ADDR_DEC     (`RCD_IDX_DEC << 2)
`define RCD_ADDR_ITP     (`RCD_IDX_ITP << 2)
`define RCD_ADDR_RSC     (`RCD_IDX_RSC << 2)
`define RCD_ADDR_C5      (`RCD_IDX_C5 << 2)
`define RCD_ADDR_STAT    (`RCD_IDX_STAT << 2)
// ----------------------------------------
// Field positions and limits
// ----------------------------------------
`define RCD_DEC_W        12
`define RCD_ITP_W        9
`define RCD_RSC_W        12
`define RCD_RSC_HI       9
`define RCD_RSC_LO       5
`define RCD_C5D_HI       5
`define RCD_C5S_HI       12
`define RCD_C5S_LO       8
`define RCD_C5D_MIN      6'h02
`define RCD_C5D_MAX      6'h20
`define RCD_C5D_RST      6'h02
`define RCD_C5S_MAX      5'h14
`define RCD_C5_EXTRA     5'h05
`define RCD_RESP_OKAY    2'h0
`define RCD_RESP_SLVERR  2'h2
`endif

/* rtl/rcd_pkg.sv */
package rcd_pkg;
  // ----------------------------------------
  // Bus carriers
  // ----------------------------------------
  typedef struct packed {
    logic        awvalid;
    logic [11:0] awaddr;
    logic        wvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bready;
    logic        arvalid;
    logic [11:0] araddr;
    logic        rready;
  } rcd_axi_in_t;
  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } rcd_axi_out_t;
endpackage : rcd_pkg

/* rtl/rcd_top.sv */
// The implementer's own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "rcd_regs.svh"
module rcd_top import rcd_pkg::*; #(
  parameter int W  = 16,
  parameter int OW = 20
) (
  input  logic           clock,
  input  logic           rst_b,
  input  rcd_axi_in_t    axi_in,
  output rcd_axi_out_t   axi_out,
  input  logic           in_valid,
  input  logic [W-1:0]   in_i,
  input  logic [W-1:0]   in_q,
  output logic           in_ready,
  output logic           out_valid,
  output logic [OW-1:0]  out_i,
  output logic [OW-1:0]  out_q
);
  localparam int RW = W + 24;
  localparam int CW = W + 26;

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    rcd_axi_out_t              ax;
    logic                      aw_ok;
    logic                      w_ok;
    logic [11:0]               waddr;
    logic [31:0]               wdata;
    logic [3:0]                wstrb;
    logic [`RCD_DEC_W-1:0]     dec;
    logic [`RCD_ITP_W-1:0]     itp;
    logic [`RCD_RSC_W-1:0]     rsc;
    logic [5:0]                c5d;
    logic [4:0]                c5s;
    logic                      rdy;
    logic [`RCD_ITP_W-1:0]     lcnt;
    logic [`RCD_DEC_W-1:0]     mcnt;
    logic [1:0][1:0][RW-1:0]   ri;
    logic [1:0][1:0][RW-1:0]   rc;
    logic                      r_valid;
    logic [1:0][W-1:0]         r_data;
    logic [1:0][4:0][CW-1:0]   ci;
    logic [1:0][4:0][CW-1:0]   cc;
    logic [5:0]                c5cnt;
    logic                      o_valid;
    logic [1:0][OW-1:0]        o_data;
    logic [15:0]               ocount;
  } rcd_state_t;

  rcd_state_t st;
  rcd_state_t next_st;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] be);
    logic [31:0] m;
    m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    return (old & ~m) | (nw & m);
  endfunction : merge

  logic in_fire;
  logic bypass;
  assign in_fire = in_valid & st.rdy;
  assign bypass  = (st.dec == '0) && (st.itp == '0);

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    logic [31:0]        wv;
    logic [31:0]        rv;
    logic               step;
    logic [1:0][RW-1:0] x;
    logic [RW-1:0]      d;
    logic [RW-1:0]      t;
    logic [CW-1:0]      v;
    logic [CW-1:0]      u;
    logic [4:0]         rs;
    logic [5:0]         cs;
    wv = '0;
    rv = '0;
    step = 1'b0;
    x = '0;
    d = '0;
    t = '0;
    v = '0;
    u = '0;
    rs = st.rsc[`RCD_RSC_HI:`RCD_RSC_LO];
    cs = {1'b0, st.c5s} + {1'b0, `RCD_C5_EXTRA};
    next_st = st;
    next_st.r_valid = 1'b0;
    next_st.o_valid = 1'b0;
    // Write channel
    if (axi_in.awvalid && st.ax.awready) begin
      next_st.aw_ok = 1'b1;
      next_st.waddr = axi_in.awaddr;
      next_st.ax.awready = 1'b0;
    end
    if (axi_in.wvalid && st.ax.wready) begin
      next_st.w_ok = 1'b1;
      next_st.wdata = axi_in.wdata;
      next_st.wstrb = axi_in.wstrb;
      next_st.ax.wready = 1'b0;
    end
    if (st.aw_ok && st.w_ok && !st.ax.bvalid) begin
      next_st.aw_ok = 1'b0;
      next_st.w_ok = 1'b0;
      next_st.ax.bvalid = 1'b1;
      next_st.ax.bresp = `RCD_RESP_OKAY;
      case (st.waddr)
        `RCD_ADDR_DEC: begin
          wv = merge({20'h0, st.dec}, st.wdata, st.wstrb);
          next_st.dec = wv[`RCD_DEC_W-1:0];
        end
        `RCD_ADDR_ITP: begin
          wv = merge({23'h0, st.itp}, st.wdata, st.wstrb);
          next_st.itp = wv[`RCD_ITP_W-1:0];
        end
        `RCD_ADDR_RSC: begin
          wv = merge({20'h0, st.rsc}, st.wdata, st.wstrb);
          next_st.rsc = wv[`RCD_RSC_W-1:0];
        end
        `RCD_ADDR_C5: begin
          wv = merge({19'h0, st.c5s, 2'h0, st.c5d}, st.wdata, st.wstrb);
          if (wv[`RCD_C5D_HI:0] < `RCD_C5D_MIN) begin
            next_st.c5d = `RCD_C5D_MIN;
          end else if (wv[`RCD_C5D_HI:0] > `RCD_C5D_MAX) begin
            next_st.c5d = `RCD_C5D_MAX;
          end else begin
            next_st.c5d = wv[`RCD_C5D_HI:0];
          end
          if (wv[`RCD_C5S_HI:`RCD_C5S_LO] > `RCD_C5S_MAX) begin
            next_st.c5s = `RCD_C5S_MAX;
          end else begin
            next_st.c5s = wv[`RCD_C5S_HI:`RCD_C5S_LO];
          end
          next_st.c5cnt = '0;
        end
        `RCD_ADDR_STAT: begin
          next_st.ax.bresp = `RCD_RESP_OKAY;
        end
        default: begin
          next_st.ax.bresp = `RCD_RESP_SLVERR;
        end
      endcase
    end
    if (st.ax.bvalid && axi_in.bready) begin
      next_st.ax.bvalid = 1'b0;
      next_st.ax.awready = 1'b1;
      next_st.ax.wready = 1'b1;
    end
    // Read channel
    if (axi_in.arvalid && st.ax.arready) begin
      next_st.ax.arready = 1'b0;
      next_st.ax.rvalid = 1'b1;
      next_st.ax.rresp = `RCD_RESP_OKAY;
      case (axi_in.araddr)
        `RCD_ADDR_DEC:  rv = {20'h0, st.dec};
        `RCD_ADDR_ITP:  rv = {23'h0, st.itp};
        `RCD_ADDR_RSC:  rv = {20'h0, st.rsc};
        `RCD_ADDR_C5:   rv = {19'h0, st.c5s, 2'h0, st.c5d};
        `RCD_ADDR_STAT: rv = {16'h0, st.ocount};
        default: begin
          rv = '0;
          next_st.ax.rresp = `RCD_RESP_SLVERR;
        end
      endcase
      next_st.ax.rdata = rv;
    end
    if (st.ax.rvalid && axi_in.rready) begin
      next_st.ax.rvalid = 1'b0;
      next_st.ax.arready = 1'b1;
    end
    // Resampler with zero stuffing
    if (in_fire) begin
      x[0] = {{(RW-W){in_i[W-1]}}, in_i};
      x[1] = {{(RW-W){in_q[W-1]}}, in_q};
      step = 1'b1;
      next_st.lcnt = st.itp;
    end else if (st.lcnt != '0) begin
      step = 1'b1;
      next_st.lcnt = st.lcnt - 1'b1;
    end
    next_st.rdy = (next_st.lcnt == '0) || bypass;
    if (bypass) begin
      next_st.lcnt = '0;
      if (in_fire) begin
        for (int c = 0; c < 2; c++) begin
          t = RW'($signed(x[c]) >>> rs);
          next_st.r_data[c] = t[W-1:0];
        end
        next_st.r_valid = 1'b1;
      end
    end else if (step) begin
      for (int c = 0; c < 2; c++) begin
        next_st.ri[c][0] = st.ri[c][0] + x[c];
        next_st.ri[c][1] = st.ri[c][1] + next_st.ri[c][0];
      end
      if (st.mcnt == st.dec) begin
        next_st.mcnt = '0;
        for (int c = 0; c < 2; c++) begin
          d = next_st.ri[c][1] - st.rc[c][0];
          next_st.rc[c][0] = next_st.ri[c][1];
          t = d - st.rc[c][1];
          next_st.rc[c][1] = d;
          t = RW'($signed(t) >>> rs);
          next_st.r_data[c] = t[W-1:0];
        end
        next_st.r_valid = 1'b1;
      end else begin
        next_st.mcnt = st.mcnt + 1'b1;
      end
    end
    // Fifth-order decimator
    if (st.r_valid) begin
      for (int c = 0; c < 2; c++) begin
        v = {{(CW-W){st.r_data[c][W-1]}}, st.r_data[c]};
        for (int k = 0; k < 5; k++) begin
          next_st.ci[c][k] = st.ci[c][k] + v;
          v = next_st.ci[c][k];
        end
      end
      if (st.c5cnt >= st.c5d - 1'b1) begin
        next_st.c5cnt = '0;
        for (int c = 0; c < 2; c++) begin
          v = next_st.ci[c][4];
          for (int k = 0; k < 5; k++) begin
            u = v - st.cc[c][k];
            next_st.cc[c][k] = v;
            v = u;
          end
          v = CW'($signed(v) >>> cs);
          next_st.o_data[c] = v[OW-1:0];
        end
        next_st.o_valid = 1'b1;
        next_st.ocount = st.ocount + 1'b1;
      end else begin
        next_st.c5cnt = st.c5cnt + 1'b1;
      end
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      st <= '0;
      st.ax.awready <= 1'b1;
      st.ax.wready <= 1'b1;
      st.ax.arready <= 1'b1;
      st.c5d <= `RCD_C5D_RST;
      st.rdy <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  assign axi_out   = st.ax;
  assign in_ready  = st.rdy;
  assign out_valid = st.o_valid;
  assign out_i     = st.o_data[0];
  assign out_q     = st.o_data[1];

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);
  logic wr_go;
  assign wr_go = st.aw_ok && st.w_ok && !st.ax.bvalid && (st.wstrb == 4'hf);

  chk_dec_write: assert property (wr_go && st.waddr == `RCD_ADDR_DEC
      |=> st.dec == $past(st.wdata[`RCD_DEC_W-1:0]))
    else $error("decimation register not written");
  chk_itp_write: assert property (wr_go && st.waddr == `RCD_ADDR_ITP
      |=> st.itp == $past(st.wdata[`RCD_ITP_W-1:0]))
    else $error("interpolation register not written");
  chk_rsc_write: assert property (wr_go && st.waddr == `RCD_ADDR_RSC
      |=> st.rsc == $past(st.wdata[`RCD_RSC_W-1:0]))
    else $error("scale register not written");
  chk_bypass_scale: assert property (bypass && in_fire && $stable(st.rsc)
      |=> st.r_valid && st.r_data[0] == W'($signed($past(in_i)) >>> $past(st.rsc[`RCD_RSC_HI:`RCD_RSC_LO])))
    else $error("bypass path wrong");
  chk_c5_range: assert property (st.c5d >= `RCD_C5D_MIN && st.c5d <= `RCD_C5D_MAX)
    else $error("decimation out of range");
  chk_c5_scale: assert property (st.c5s <= `RCD_C5S_MAX)
    else $error("scale out of range");
  chk_out_group: assert property (out_valid |-> $past(st.r_valid) && $past(st.c5cnt) >= $past(st.c5d) - 6'h01)
    else $error("output without full group");
  chk_stuff_stall: assert property (in_fire && !bypass && st.itp == 9'h001 |=> !in_ready ##1 in_ready)
    else $error("zero stuffing stall wrong");
  chk_c5_feed: assert property (st.r_valid && st.c5cnt < st.c5d - 6'h01 |=> st.c5cnt == $past(st.c5cnt) + 6'h01)
    else $error("filter input not consumed");

  cov_bypass: cover property (bypass && in_fire);
  cov_stuff: cover property (!bypass && in_fire ##1 !in_ready);
  cov_output: cover property (out_valid);
  cov_write: cover property (st.ax.bvalid && axi_in.bready);
endmodule : rcd_top

/* testbench/rcd_src.sv */
`timescale 1ns/1ps
// ----------------------------------------
// Upstream sample source
// ----------------------------------------
module rcd_src import rcd_pkg::*; #(
  parameter int W = 16
) (
  input  logic         clock,
  input  logic         rst_b,
  input  logic         in_ready,
  input  logic         go,
  input  logic         slow,
  input  logic [15:0]  n,
  input  logic [W-1:0] x,
  output logic         in_valid,
  output logic [W-1:0] in_i,
  output logic [W-1:0] in_q,
  output logic         idle
);
  logic [15:0] left;
  assign idle = (left == 16'h0000) && !in_valid;
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      left     <= 16'h0000;
      in_valid <= 1'b0;
      in_i     <= '0;
      in_q     <= '0;
    end else if (go) begin
      left     <= n;
      in_valid <= 1'b1;
      in_i     <= x;
      in_q     <= -x;
    end else if (in_valid && in_ready) begin
      left     <= left - 16'h0001;
      in_valid <= (left > 16'h0001) && !slow;
      if ((left == 16'h0001) || slow) begin
        in_i <= ~x;
        in_q <= x;
      end
    end else if (left != 16'h0000) begin
      in_valid <= 1'b1;
      in_i     <= x;
      in_q     <= -x;
    end
  end
endmodule : rcd_src

/* testbench/tb_rcd_top.sv */
`timescale 1ns/1ps
`include "rcd_regs.svh"
module tb_rcd_top import rcd_pkg::*;;
  logic         clock, rst_b, go, slow, in_valid, in_ready, out_valid, idle;
  logic [15:0]  n, xv, in_i, in_q;
  logic [19:0]  out_i, out_q, li, lq;
  rcd_axi_in_t  ai;
  rcd_axi_out_t ao;
  int           err_total, checks, np, lo, tot, rs, ip, gn, gd;
  rcd_top rcd_top_i (.clock(clock), .rst_b(rst_b), .axi_in(ai), .axi_out(ao), .in_valid(in_valid),
    .in_i(in_i), .in_q(in_q), .in_ready(in_ready), .out_valid(out_valid), .out_i(out_i), .out_q(out_q));
  rcd_src rcd_src_i (.clock(clock), .rst_b(rst_b), .in_ready(in_ready), .go(go), .slow(slow), .n(n),
    .x(xv), .in_valid(in_valid), .in_i(in_i), .in_q(in_q), .idle(idle));
  // ----------------------------------------
  // Clock, monitor, watchdog
  // ----------------------------------------
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  always @(posedge clock) begin
    if (out_valid === 1'b1) begin
      np++;
      li = out_i;
      lq = out_q;
    end
    if (in_ready === 1'b0) lo++;
  end
  initial begin
    repeat (30000) @(posedge clock);
    err_total++;
    end_of_test;
  end
  // ----------------------------------------
  // Compare and bus tasks
  // ----------------------------------------
  task automatic cmp_reg(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      err_total++;
      $display("Error t=%0t got %h exp %h", $time, g, e);
    end
  endtask : cmp_reg
  task automatic cmp_smp(input logic [19:0] g, input logic [19:0] e);
    checks++;
    if (g !== e) begin
      err_total++;
      $display("Error t=%0t got %h exp %h", $time, g, e);
    end
  endtask : cmp_smp
  task automatic axw(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
    bit dn;
    dn = 0;
    r = 2'h3;
    ai.awaddr <= a;
    ai.wdata <= d;
    ai.wstrb <= 4'hf;
    ai.awvalid <= 1'b1;
    ai.wvalid <= 1'b1;
    ai.bready <= 1'b1;
    for (int k = 0; k < 64 && !dn; k++) begin
      @(posedge clock);
      if (ai.awvalid && ao.awready) ai.awvalid <= 1'b0;
      if (ai.wvalid && ao.wready) ai.wvalid <= 1'b0;
      if (ao.bvalid) begin
        r = ao.bresp;
        ai.bready <= 1'b0;
        dn = 1;
      end
    end
    @(posedge clock);
  endtask : axw
  task automatic axr(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    bit dn;
    dn = 0;
    r = 2'h3;
    d = 32'hdead0000;
    ai.araddr <= a;
    ai.arvalid <= 1'b1;
    ai.rready <= 1'b1;
    for (int k = 0; k < 64 && !dn; k++) begin
      @(posedge clock);
      if (ai.arvalid && ao.arready) ai.arvalid <= 1'b0;
      if (ao.rvalid) begin
        d = ao.rdata;
        r = ao.rresp;
        ai.rready <= 1'b0;
        dn = 1;
      end
    end
    @(posedge clock);
  endtask : axr
  task automatic wchk(input logic [11:0] a, input logic [31:0] d);
    logic [1:0] r;
    axw(a, d, r);
    cmp_reg({30'h0, r}, {30'h0, `RCD_RESP_OKAY});
  endtask : wchk
  task automatic rchk(input logic [11:0] a, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0]  r;
    axr(a, d, r);
    cmp_reg(d, e);
  endtask : rchk
  function automatic logic [19:0] cic_exp(input logic [15:0] x, input int m, input int s);
    longint v;
    v = (longint'($signed(x)) * gn / gd) >>> rs;
    return 20'((v * (m ** 5)) >>> (s + 5));
  endfunction : cic_exp
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_regs;
    logic [31:0] d;
    logic [1:0]  r;
    rchk(`RCD_ADDR_DEC, 32'h0);
    rchk(`RCD_ADDR_ITP, 32'h0);
    rchk(`RCD_ADDR_RSC, 32'h0);
    wchk(`RCD_ADDR_DEC, 32'hffffffff);
    rchk(`RCD_ADDR_DEC, 32'h00000fff);
    wchk(`RCD_ADDR_ITP, 32'hffffffff);
    rchk(`RCD_ADDR_ITP, 32'h000001ff);
    wchk(`RCD_ADDR_RSC, 32'h000003ff);
    rchk(`RCD_ADDR_RSC, 32'h000003ff);
    wchk(`RCD_ADDR_C5, 32'h00001f3f);
    rchk(`RCD_ADDR_C5, 32'h00001420);
    wchk(`RCD_ADDR_C5, 32'h00000001);
    rchk(`RCD_ADDR_C5, 32'h00000002);
    axw(12'h000, 32'h1, r);
    cmp_reg({30'h0, r}, {30'h0, `RCD_RESP_SLVERR});
    axr(12'h000, d, r);
    cmp_reg({d[29:0], r}, {30'h0, `RCD_RESP_SLVERR});
  endtask : t_regs
  task automatic t_cfg(input logic [11:0] d, input logic [8:0] i, input logic [11:0] s);
    wchk(`RCD_ADDR_DEC, {20'h0, d});
    wchk(`RCD_ADDR_ITP, {23'h0, i});
    wchk(`RCD_ADDR_RSC, {20'h0, s});
    rs = int'(s[9:5]);
    ip = int'(i);
    gn = (int'(d) + 1) * (int'(d) + 1);
    gd = int'(i) + 1;
  endtask : t_cfg
  task automatic t_run(input int m, input int s, input logic [15:0] x, input int k, input bit sl, input bit cv);
    logic [31:0] d;
    logic [1:0]  r;
    wchk(`RCD_ADDR_C5, {19'h0, 5'(s), 2'h0, 6'(m)});
    np = 0;
    lo = 0;
    slow <= sl;
    n <= 16'(k);
    xv <= x;
    go <= 1'b1;
    @(posedge clock);
    go <= 1'b0;
    @(posedge clock);
    for (int j = 0; j < 8000 && !(idle === 1'b1); j++) @(posedge clock);
    repeat (8) @(posedge clock);
    cmp_reg(32'(np), 32'(k / m));
    if (cv) cmp_smp(li, cic_exp(x, m, s));
    if (cv) cmp_smp(lq, cic_exp(-x, m, s));
    if (!sl) cmp_reg(32'(lo), 32'(k * ip));
    tot += k / m;
    rchk(`RCD_ADDR_STAT, 32'(tot[15:0]));
  endtask : t_run
  task automatic end_of_test;
    $display("errors %0d checks %0d", err_total, checks);
    if (err_total == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : end_of_test
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    ai = '0;
    rst_b = 1'b0;
    go = 1'b0;
    slow = 1'b0;
    n = 16'h0;
    xv = 16'h0;
    repeat (16) @(posedge clock);
    rst_b <= 1'b1;
    @(posedge clock);
    t_regs;
    t_cfg(12'h0, 9'h0, 12'h0);
    t_run(2, 0, 16'd100, 40, 0, 1);
    t_run(32, 20, 16'd1000, 320, 0, 1);
    t_cfg(12'h0, 9'h0, 12'h042);
    t_run(4, 5, 16'd400, 64, 1, 1);
    t_cfg(12'h1, 9'h1, 12'h0);
    t_run(2, 0, 16'd100, 40, 0, 1);
    end_of_test;
  end
endmodule : tb_rcd_top
